/* File: core/event_status_flag_bank.sv */
// event_status_flag_bank: hierarchical sticky event flags with summary.
// assumes a byte register port on clk; event inputs are asynchronous
// levels, turned into rising-edge events after synchronising.
// Function
// RULE1: event flags sticky, write one clears
// RULE2: writing zero leaves flag unchanged
// RULE3: timeout bit read-only, hardware-cleared when others clear
// RULE4: global bit 5 latches battery undervoltage
// RULE5: global bit 4 on overtemp/overcurrent detail set
// RULE6: global bit 3 on voltage monitor detail set
// RULE7: global bit 2 on serial error detail set
// RULE8: global bit 1 on processor detail set
// RULE9: global bit 0 on system detail set
// RULE10: system fault bits 7..4 reference and supply
// RULE11: system fault bit 0 fuse double error
// RULE12: system interrupt bits 7,6 reference mismatch warnings
// RULE13: system interrupt bit 5 wake-up cause
// RULE14: system interrupt bit 3 sync clock fault
// RULE15: system interrupt bit 1 voltage config fault
// RULE16: system interrupt bit 0 supervision config fault
// RULE17: processor bits 7,6,3 resets and watchdog
// RULE18: processor bit 0 init timer error
// RULE19: watchdog miss bit 3, others unused
// RULE20: summary set on detail set event only
// RULE21: clearing summary leaves detail registers alone
// RULE22: clearing detail leaves summary bit alone
// RULE23: unused bits zero; set beats clear
// RULE24: software reads detail then clears both
`timescale 1ns/10ps
module event_status_flag_bank (
	input wire logic clk,
	input wire logic resetn,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [esfb_pkg::ESFB_AW-1:0] regAddr,
	input wire logic [esfb_pkg::ESFB_DW-1:0] regWdata,
	output logic [esfb_pkg::ESFB_DW-1:0] regRdata,
	output logic regRvalid,
	input wire logic [7:0] sysFaultIn,
	input wire logic [7:0] sysIntIn,
	input wire logic wakeFromEnable,
	input wire logic [7:0] procFaultIn,
	input wire logic [7:0] wdMissIn,
	input wire logic batteryUvIn,
	input wire logic timeoutIn,
	input wire logic serialErrEvt,
	input wire logic monitorEvt,
	input wire logic otocEvt,
	output logic [7:0] globalFlags
);
	import esfb_pkg::*;

	localparam int NIN = 36;
	logic [NIN-1:0] rawIn;
	logic [NIN-1:0] syncIn;
	logic [NIN-1:0] prevIn;
	logic [NIN-1:0] rise;
	logic [7:0] sysFltSet;
	logic [7:0] sysIntSet;
	logic [7:0] procSet;
	logic [7:0] wdSet;
	logic [7:0] sysFlt;
	logic [7:0] sysInt;
	logic [7:0] procFlt;
	logic [7:0] wdMiss;
	logic [7:0] sysFltNew;
	logic [7:0] sysIntNew;
	logic [7:0] procNew;
	logic [7:0] wdNew;
	logic [7:0] globalSet;
	logic [7:0] next_global;
	logic otherClear;

	// decode of one register address, shared by reads and writes
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	// all event lines cross through two flops before use
	assign rawIn = {sysFaultIn, sysIntIn[7:6], sysIntIn[3:0], procFaultIn,
		wdMissIn, wakeFromEnable, batteryUvIn, timeoutIn, serialErrEvt,
		monitorEvt, otocEvt};
	esfb_sync #(.W(NIN)) u_sync (
		.clk(clk),
		.resetn(resetn),
		.din(rawIn),
		.dout(syncIn)
	);

	// rising edges only: a held level must not re-set a cleared flag
	always_ff @(posedge clk)
	begin
		if (!resetn)
			prevIn <= '0;
		else
			prevIn <= syncIn;
	end
	assign rise = syncIn & ~prevIn;

	// map events onto flag positions; masks drop unused bits
	assign sysFltSet = rise[35:28]; // RULE10 RULE11
	assign sysIntSet = {rise[27:26], 1'b0, 1'b0, rise[25:22]} // RULE12
		| (rise[5] ? 8'h20 : 8'h00); // RULE13
	assign procSet = rise[21:14]; // RULE17 RULE18
	assign wdSet = rise[13:6]; // RULE19

	esfb_flag_reg #(.MASK(MASK_SYSFLT)) u_sysflt (
		.clk(clk),
		.resetn(resetn),
		.setEvt(sysFltSet), // RULE10 RULE11
		.clrStb(regWrite && hit(regAddr, OFS_SYSFLT)),
		.clrData(regWdata),
		.flags(sysFlt),
		.newSet(sysFltNew)
	);
	// bit 5 carries the enable-input wake-up cause; bits 3..0 the faults
	esfb_flag_reg #(.MASK(MASK_SYSINT)) u_sysint (
		.clk(clk),
		.resetn(resetn),
		.setEvt(sysIntSet), // RULE14 RULE15 RULE16
		.clrStb(regWrite && hit(regAddr, OFS_SYSINT)),
		.clrData(regWdata),
		.flags(sysInt),
		.newSet(sysIntNew)
	);
	esfb_flag_reg #(.MASK(MASK_PROCFLT)) u_proc (
		.clk(clk),
		.resetn(resetn),
		.setEvt(procSet), // RULE17 RULE18
		.clrStb(regWrite && hit(regAddr, OFS_PROCFLT)),
		.clrData(regWdata),
		.flags(procFlt),
		.newSet(procNew)
	);
	esfb_flag_reg #(.MASK(MASK_WDMISS)) u_wd (
		.clk(clk),
		.resetn(resetn),
		.setEvt(wdSet), // RULE19
		.clrStb(regWrite && hit(regAddr, OFS_WDMISS)),
		.clrData(regWdata),
		.flags(wdMiss),
		.newSet(wdNew)
	);

	// summary bits 1,0 set from new detail sets, bits 7 and 5..2 from rising edges, never from levels
	always_comb
	begin
		globalSet = 8'h00;
		globalSet[GB_SYS] = |{sysFltNew, sysIntNew}; // RULE9 RULE20
		globalSet[GB_PROC] = |{procNew, wdNew}; // RULE8
		globalSet[GB_SERIAL] = rise[2]; // RULE7
		globalSet[GB_MON] = rise[1]; // RULE6
		globalSet[GB_OTOC] = rise[0]; // RULE5
		globalSet[GB_BATUV] = rise[4]; // RULE4
		globalSet[GB_TIMEOUT] = rise[3]; // RULE3
	end

	// write-one-to-clear on bits 5..0; bit 7 only hardware clears
	always_comb
	begin
		next_global = globalFlags;
		if (regWrite && hit(regAddr, OFS_GLOBAL))
			next_global = next_global & ~(regWdata & MASK_GLOBAL_W1C); // RULE1 RULE2 RULE21
		next_global = next_global | globalSet; // RULE23
		otherClear = (next_global & MASK_GLOBAL_W1C) == 8'h00;
		if (otherClear && !globalSet[GB_TIMEOUT])
			next_global[GB_TIMEOUT] = 1'b0; // RULE3
		next_global[6] = 1'b0;
	end

	// detail clears never touch the summary; only its own write and the timeout hardware clear do
	always_ff @(posedge clk)
	begin
		if (!resetn)
			globalFlags <= RST_FLAGS;
		else
			globalFlags <= next_global; // RULE22
	end

	// registered read port, unmapped addresses read zero
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			regRdata <= 8'h00;
			regRvalid <= 1'b0;
		end
		else
		begin
			regRvalid <= regRead;
			if (!regRead)
				regRdata <= 8'h00;
			else if (hit(regAddr, OFS_GLOBAL))
				regRdata <= globalFlags;
			else if (hit(regAddr, OFS_SYSFLT))
				regRdata <= sysFlt;
			else if (hit(regAddr, OFS_SYSINT))
				regRdata <= sysInt;
			else if (hit(regAddr, OFS_PROCFLT))
				regRdata <= procFlt;
			else if (hit(regAddr, OFS_WDMISS))
				regRdata <= wdMiss;
			else
				regRdata <= 8'h00; // RULE23
		end
	end

	// a rising detail event reaches the summary in one cycle
	a_sys_summary: assert property ( // RULE9
		@(posedge clk) disable iff (!resetn)
		(|sysFltNew) |=> globalFlags[GB_SYS])
		else $error("system summary not set");
	a_sysint_summary: assert property ( // RULE9
		@(posedge clk) disable iff (!resetn)
		(|sysIntNew) |=> globalFlags[GB_SYS])
		else $error("system summary not set by interrupt flag");
	a_proc_summary: assert property ( // RULE8
		@(posedge clk) disable iff (!resetn)
		(|wdNew) |=> globalFlags[GB_PROC] && wdMiss[3])
		else $error("processor summary not set");
	a_procflt_summary: assert property ( // RULE8
		@(posedge clk) disable iff (!resetn)
		(|procNew) |=> globalFlags[GB_PROC])
		else $error("processor summary not set by fault flag");
	// the single lines have no detail register here, so a rise sets them
	a_batt_summary: assert property ( // RULE4
		@(posedge clk) disable iff (!resetn)
		rise[4] |=> globalFlags[GB_BATUV])
		else $error("battery summary not set");
	a_otoc_summary: assert property ( // RULE5
		@(posedge clk) disable iff (!resetn)
		rise[0] |=> globalFlags[GB_OTOC])
		else $error("overtemperature summary not set");
	a_mon_summary: assert property ( // RULE6
		@(posedge clk) disable iff (!resetn)
		rise[1] |=> globalFlags[GB_MON])
		else $error("monitor summary not set");
	a_serial_summary: assert property ( // RULE7
		@(posedge clk) disable iff (!resetn)
		rise[2] |=> globalFlags[GB_SERIAL])
		else $error("serial summary not set");
	a_timeout_set: assert property ( // RULE3
		@(posedge clk) disable iff (!resetn)
		rise[3] |=> globalFlags[GB_TIMEOUT])
		else $error("timeout summary not set");
	// a level that stays high must not bring a cleared summary back
	a_level_quiet: assert property ( // RULE20
		@(posedge clk) disable iff (!resetn)
		(|sysFlt) && !globalFlags[GB_SYS] && !(|{sysFltNew, sysIntNew})
		|=> !globalFlags[GB_SYS])
		else $error("summary follows detail level");
	// write-one-to-clear: only ones clear, and a set event wins
	a_sticky_hold: assert property ( // RULE1
		@(posedge clk) disable iff (!resetn)
		sysFlt[0] && !(regWrite && hit(regAddr, OFS_SYSFLT)) |=> sysFlt[0])
		else $error("flag lost without clear");
	a_zero_write: assert property ( // RULE2
		@(posedge clk) disable iff (!resetn)
		regWrite && hit(regAddr, OFS_PROCFLT) && !regWdata[7] && procFlt[7]
		|=> procFlt[7])
		else $error("zero write cleared flag");
	a_one_clear: assert property ( // RULE4
		@(posedge clk) disable iff (!resetn)
		regWrite && hit(regAddr, OFS_GLOBAL) && regWdata[GB_BATUV]
		&& !globalSet[GB_BATUV] |=> !globalFlags[GB_BATUV])
		else $error("battery flag not cleared");
	a_set_wins: assert property ( // RULE23
		@(posedge clk) disable iff (!resetn)
		procSet[6] && regWrite && hit(regAddr, OFS_PROCFLT) |=> procFlt[6])
		else $error("set lost to clear");
	// summary and detail registers are cleared independently
	a_detail_keeps: assert property ( // RULE21
		@(posedge clk) disable iff (!resetn)
		regWrite && hit(regAddr, OFS_GLOBAL) |=> $stable(sysInt)
		|| $past(|sysIntSet))
		else $error("summary clear touched detail");
	a_summary_keeps: assert property ( // RULE22
		@(posedge clk) disable iff (!resetn)
		regWrite && hit(regAddr, OFS_SYSFLT) && globalFlags[GB_SYS]
		|=> globalFlags[GB_SYS])
		else $error("detail clear dropped summary");
	// timeout clears only when no other summary bit stays or arrives
	a_timeout_hw: assert property ( // RULE3
		@(posedge clk) disable iff (!resetn)
		globalFlags[GB_TIMEOUT] && (globalFlags & MASK_GLOBAL_W1C) == 8'h00
		&& globalSet == 8'h00 |-> ##1 !globalFlags[GB_TIMEOUT])
		else $error("timeout not hardware cleared");
	a_timeout_ro: assert property ( // RULE3
		@(posedge clk) disable iff (!resetn)
		regWrite && hit(regAddr, OFS_GLOBAL) && globalFlags[GB_TIMEOUT]
		&& |(globalFlags[5:0] & ~regWdata[5:0]) |=> globalFlags[GB_TIMEOUT])
		else $error("timeout bit cleared by write");
	// unused positions stay zero, unmapped reads answer zero
	a_unused_zero: assert property ( // RULE23
		@(posedge clk) disable iff (!resetn)
		!globalFlags[6] && (wdMiss & ~MASK_WDMISS) == 8'h00)
		else $error("unused bit set");
	a_unused_detail: assert property ( // RULE23
		@(posedge clk) disable iff (!resetn)
		(sysFlt & ~MASK_SYSFLT) == 8'h00 && (sysInt & ~MASK_SYSINT) == 8'h00
		&& (procFlt & ~MASK_PROCFLT) == 8'h00)
		else $error("unused detail bit set");
	a_read_unmapped: assert property ( // RULE23
		@(posedge clk) disable iff (!resetn)
		regRead && regAddr > OFS_WDMISS |=> regRvalid && regRdata == 8'h00)
		else $error("unmapped read not zero");
	// fuse error in two steps: a new detail set, then flag and summary
	sequence s_fuse_set;
		sysFltSet[0] && !sysFlt[0];
	endsequence
	sequence s_fuse_seen;
		##1 (sysFlt[0] && globalFlags[GB_SYS]);
	endsequence
	a_fuse_path: assert property ( // RULE11
		@(posedge clk) disable iff (!resetn)
		s_fuse_set |-> s_fuse_seen)
		else $error("fuse error event not latched");
	// missed trigger in two steps: a new detail set, then flag and summary
	sequence s_miss_set;
		wdSet[3] && !wdMiss[3];
	endsequence
	sequence s_miss_seen;
		##1 (wdMiss[3] && globalFlags[GB_PROC]);
	endsequence
	a_miss_latch: assert property ( // RULE19
		@(posedge clk) disable iff (!resetn)
		s_miss_set |-> s_miss_seen)
		else $error("watchdog miss not latched");
	a_wake_cause: assert property ( // RULE13
		@(posedge clk) disable iff (!resetn)
		rise[5] |=> sysInt[SI_WAKE])
		else $error("wake-up cause not latched");
endmodule // event_status_flag_bank

/* File: inc/esfb_pkg.sv */
// esfb_pkg: constants shared by the event status flag bank.
// assumes an 8-bit register port with byte-wide data.
package esfb_pkg;
	localparam int ESFB_DW = 8;
	localparam int ESFB_AW = 8;
	// register offsets
	localparam logic [7:0] OFS_GLOBAL = 8'h1a;
	localparam logic [7:0] OFS_SYSFLT = 8'h1b;
	localparam logic [7:0] OFS_SYSINT = 8'h1c;
	localparam logic [7:0] OFS_PROCFLT = 8'h1d;
	localparam logic [7:0] OFS_WDMISS = 8'h1e;
	// reset values
	localparam logic [7:0] RST_FLAGS = 8'h00;
	// implemented-bit masks, write-one-to-clear bits for global; all other detail bits read zero
	localparam logic [7:0] MASK_GLOBAL_W1C = 8'h3f;
	localparam logic [7:0] MASK_SYSFLT = 8'hf1;
	localparam logic [7:0] MASK_SYSINT = 8'hef;
	localparam logic [7:0] MASK_PROCFLT = 8'hc9;
	localparam logic [7:0] MASK_WDMISS = 8'h08;
	// global bit positions
	localparam int GB_SYS = 0;
	localparam int GB_PROC = 1;
	localparam int GB_SERIAL = 2;
	localparam int GB_MON = 3;
	localparam int GB_OTOC = 4;
	localparam int GB_BATUV = 5;
	localparam int GB_TIMEOUT = 7;
	// system interrupt bit of the wake-up cause
	localparam int SI_WAKE = 5;
endpackage

/* File: core/esfb_flag_reg.sv */
// esfb_flag_reg: one byte of sticky write-one-to-clear flags.
// assumes set pulses and write strobe are on clk.
`timescale 1ns/10ps
module esfb_flag_reg #(
	parameter logic [7:0] MASK = 8'hff
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] setEvt,
	input wire logic clrStb,
	input wire logic [7:0] clrData,
	output logic [7:0] flags,
	output logic [7:0] newSet
);
	import esfb_pkg::*;
	logic [7:0] next_flags;
	// set wins over a coinciding clear; zeros written change nothing
	always_comb
	begin
		next_flags = flags & ~(clrStb ? clrData : 8'h00); // RULE1 RULE2
		next_flags = (next_flags | setEvt) & MASK; // RULE23
	end
	always_ff @(posedge clk)
	begin
		if (!resetn)
			flags <= RST_FLAGS;
		else
			flags <= next_flags;
	end
	// a flag going from clear to set is one summary event
	assign newSet = setEvt & MASK & ~flags; // RULE20
endmodule // esfb_flag_reg

/* File: core/esfb_sync.sv */
// esfb_sync: two-stage synchroniser for a vector of event levels.
// assumes inputs may come from analog monitors, asynchronous to clk.
`timescale 1ns/10ps
module esfb_sync #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta;
	// first stage is read only by the second
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			meta <= '0;
			dout <= '0;
		end
		else
		begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule // esfb_sync

/* File: verification/esfb_mcu_model.sv */
// esfb_mcu_model: microcontroller side that reads and clears the flags.
// assumes strobes are taken on the rising clk edge, answer one cycle on.
`timescale 1ns/10ps
module esfb_mcu_model (
	input wire logic clk,
	output logic regWrite,
	output logic regRead,
	output logic [7:0] regAddr,
	output logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire logic regRvalid
);
	// idle bus at time zero
	initial
	begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWdata = 8'h00;
	end
	// one write strobe; released lines toggle so stale values never match
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		regWrite = 1'b1;
		regAddr = a;
		regWdata = d;
		@(posedge clk) #1;
		regWrite = 1'b0;
		regAddr = ~a;
		regWdata = ~d;
	endtask
	// the answer stands one cycle only, so it is taken in that cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		@(posedge clk) #1;
		regRead = 1'b1;
		regAddr = a;
		@(posedge clk) #1;
		regRead = 1'b0;
		regAddr = ~a;
		d = regRdata;
		v = regRvalid;
	endtask
endmodule // esfb_mcu_model

/* File: verification/event_status_flag_bank_tb.sv */
// event_status_flag_bank_tb: random events and clears against a model.
// assumes esfb_pkg offsets are contiguous from the global register.
`timescale 1ns/10ps
module event_status_flag_bank_tb;
	import esfb_pkg::*;
	logic clk, resetn, regWrite, regRead, regRvalid, v;
	logic [7:0] regAddr, regWdata, regRdata, globalFlags, got;
	logic [7:0] ev [5];
	int m [5];
	int err_total = 0, n_tests = 0, seed = 24891, cyc = 0, k;
	// 25 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// hang guard, far above the length of the sequence
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			summarize();
		end
	end
	event_status_flag_bank i_dut (.clk(clk), .resetn(resetn),
		.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
		.regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
		.sysFaultIn(ev[0]), .sysIntIn(ev[1]), .wakeFromEnable(ev[4][0]),
		.procFaultIn(ev[2]), .wdMissIn(ev[3]), .batteryUvIn(ev[4][5]),
		.timeoutIn(ev[4][7]), .serialErrEvt(ev[4][2]),
		.monitorEvt(ev[4][3]), .otocEvt(ev[4][4]),
		.globalFlags(globalFlags));
	esfb_mcu_model i_mcu (.clk(clk), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
		.regRdata(regRdata), .regRvalid(regRvalid));
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// timeout summary bit cannot outlive the other summary bits
	task automatic tidy();
		if ((m[0] & 63) == 0)
			m[0] &= ~128;
	endtask
	// model of one rising edge on every event line; only flags that
	// were clear count as new and reach the summary
	task automatic fire();
		int a, b, c;
		a = ev[0] & MASK_SYSFLT & ~m[1];
		b = ((ev[1] & 8'hcf) | (ev[4][0] << 5)) & ~m[2];
		c = (ev[2] & MASK_PROCFLT & ~m[3]) | (ev[3] & MASK_WDMISS & ~m[4]);
		m[1] |= a;
		m[2] |= b;
		m[3] |= ev[2] & MASK_PROCFLT;
		m[4] |= ev[3] & MASK_WDMISS;
		m[0] |= (ev[4] & 8'hbc) | ((a | b) != 0) | ((c != 0) << 1);
		tidy();
	endtask
	// write ones to clear; read-only global bits ignore the write
	task automatic clr(input int r, input logic [7:0] d);
		i_mcu.wr(OFS_GLOBAL + r[7:0], d);
		m[r] &= ~(r == 0 ? d & MASK_GLOBAL_W1C : d);
		tidy();
	endtask
	// every register plus the first unmapped address after them
	task automatic readall();
		for (int r = 0; r < 6; r++)
		begin
			i_mcu.rd(OFS_GLOBAL + r[7:0], got, v);
			chk("rvalid", 8'h01, {7'h00, v});
			chk("regRdata", r < 5 ? m[r][7:0] : 8'h00, got);
		end
		chk("globalFlags", m[0][7:0], globalFlags);
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// reset, set-against-clear race, then random event rounds
	initial
	begin
		resetn = 1'b0;
		for (k = 0; k < 5; k++)
		begin
			ev[k] = 8'h00;
			m[k] = 0;
		end
		repeat (10) @(posedge clk);
		#1 resetn = 1'b1;
		readall();
		@(posedge clk) #1 ev[0] = 8'h01;
		@(posedge clk);
		i_mcu.wr(OFS_SYSFLT, 8'h01);
		m[1] = 1;
		m[0] = 1;
		readall();
		// same race on a processor flag
		@(posedge clk) #1 ev[2] = 8'h40;
		@(posedge clk);
		i_mcu.wr(OFS_PROCFLT, 8'h40);
		m[3] = 8'h40;
		m[0] = 3;
		readall();
		// a lone timeout stands one cycle, then hardware clears it
		clr(0, 8'h3f);
		@(posedge clk) #1 ev[4] = 8'h80;
		repeat (3) @(posedge clk);
		#1 chk("timeoutFlag", 8'h80, globalFlags);
		readall();
		repeat (12)
		begin
			@(posedge clk) #1;
			for (k = 0; k < 5; k++)
				ev[k] = 8'h00;
			repeat (3) @(posedge clk);
			#1;
			for (k = 0; k < 5; k++)
				ev[k] = 8'($random(seed));
			fire();
			repeat (5) @(posedge clk);
			readall();
			clr(1 + {$random(seed)} % 4, 8'($random(seed)));
			readall();
			clr(0, 8'($random(seed)));
			readall();
		end
		summarize();
	end
endmodule // event_status_flag_bank_tb
